// ===== aial_map.svh
// address map, reset values and field positions of the analog alarm block
`ifndef AIAL_MAP_SVH
`define AIAL_MAP_SVH

`define AIAL_ADDR_W          16
`define AIAL_DATA_W          16
`define AIAL_NCH_DEF         32

// coils, one bit per channel
`define AIAL_HI_EN_BASE      16'h027C
`define AIAL_LO_EN_BASE      16'h029C
`define AIAL_HI_TYPE_BASE    16'h02BC
`define AIAL_LO_TYPE_BASE    16'h02DC
`define AIAL_HI_CLR_BASE     16'h02FC
`define AIAL_LO_CLR_BASE     16'h031C
// discrete inputs, one bit per channel
`define AIAL_HI_IND_BASE     16'h27F0
`define AIAL_LO_IND_BASE     16'h2810
// input registers, one word per channel
`define AIAL_MAX_BASE        16'h761C
`define AIAL_MIN_BASE        16'h763C
// holding registers, one word per channel
`define AIAL_HI_LIM_BASE     16'h9D68
`define AIAL_LO_LIM_BASE     16'h9D88

`define AIAL_BIT_POS         0
`define AIAL_HI_LIM_RST      16'h7FFF
`define AIAL_LO_LIM_RST      16'h8000
`define AIAL_EN_RST          1'b0
`define AIAL_TYPE_RST        1'b0
`define AIAL_MODE_MOMENTARY  1'b0
`define AIAL_MODE_LATCH      1'b1

`endif

// ===== aial_pkg.sv
// types shared by the analog alarm block and its users
package aial_pkg;
  `include "aial_map.svh"

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`AIAL_ADDR_W-1:0] addr;
    logic [`AIAL_DATA_W-1:0] wdata;
  } aial_req_t;

  typedef struct packed {
    logic                    valid;
    logic                    err;
    logic [`AIAL_DATA_W-1:0] rdata;
  } aial_rsp_t;

  typedef struct packed {
    logic                    valid;
    logic [7:0]              ch;
    logic signed [15:0]      value;
  } aial_smp_t;
endpackage

// ===== aial_alarm.sv
// per-channel high/low alarm, latch and running min/max over modbus-style registers
module aial_alarm
  import aial_pkg::*;
#(
  parameter int NCH = `AIAL_NCH_DEF
) (
  input  wire logic      core_clk_i,
  input  wire logic      srst_i,
  input  wire aial_smp_t smp_i,
  input  wire aial_req_t req_i,
  output aial_rsp_t      rsp_o,
  output logic [NCH-1:0] hi_alarm_o,
  output logic [NCH-1:0] lo_alarm_o
);

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  typedef struct packed {
    logic [NCH-1:0]             hi_en;
    logic [NCH-1:0]             lo_en;
    logic [NCH-1:0]             hi_type;
    logic [NCH-1:0]             lo_type;
    logic [NCH-1:0]             hi_ind;
    logic [NCH-1:0]             lo_ind;
    logic [NCH-1:0]             seen;
    logic [NCH-1:0][15:0]       hi_lim;
    logic [NCH-1:0][15:0]       lo_lim;
    logic [NCH-1:0][15:0]       max_v;
    logic [NCH-1:0][15:0]       min_v;
    aial_rsp_t                  rsp;
  } aial_state_t;

  aial_state_t st_r;
  aial_state_t st_nxt;

  // true when addr falls inside a per-channel group starting at base
  function automatic logic in_grp(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    return (a >= b) && (d < 16'(NCH));
  endfunction

  function automatic logic [CW-1:0] grp_idx(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    return d[CW-1:0];
  endfunction

  function automatic logic [15:0] bit_word(input logic b);
    return {15'h0000, b};
  endfunction

  always_comb begin
    logic [CW-1:0]      ix;
    logic               hi_hit;
    logic               lo_hit;
    logic               hi_clr;
    logic               lo_clr;
    logic [15:0]        a;
    ix     = '0;
    hi_hit = 1'b0;
    lo_hit = 1'b0;
    hi_clr = 1'b0;
    lo_clr = 1'b0;
    a      = req_i.addr;
    st_nxt = st_r;
    st_nxt.rsp = '0;

    // host writes; clear coil takes effect when written with 0
    if (req_i.wr) begin
      if (in_grp(a, `AIAL_HI_EN_BASE)) begin
        st_nxt.hi_en[grp_idx(a, `AIAL_HI_EN_BASE)] = req_i.wdata[`AIAL_BIT_POS];
      end
      if (in_grp(a, `AIAL_LO_EN_BASE)) begin
        st_nxt.lo_en[grp_idx(a, `AIAL_LO_EN_BASE)] = req_i.wdata[`AIAL_BIT_POS];
      end
      if (in_grp(a, `AIAL_HI_TYPE_BASE)) begin
        st_nxt.hi_type[grp_idx(a, `AIAL_HI_TYPE_BASE)] = req_i.wdata[`AIAL_BIT_POS];
      end
      if (in_grp(a, `AIAL_LO_TYPE_BASE)) begin
        st_nxt.lo_type[grp_idx(a, `AIAL_LO_TYPE_BASE)] = req_i.wdata[`AIAL_BIT_POS];
      end
      if (in_grp(a, `AIAL_HI_LIM_BASE)) begin
        st_nxt.hi_lim[grp_idx(a, `AIAL_HI_LIM_BASE)] = req_i.wdata;
      end
      if (in_grp(a, `AIAL_LO_LIM_BASE)) begin
        st_nxt.lo_lim[grp_idx(a, `AIAL_LO_LIM_BASE)] = req_i.wdata;
      end
    end

    // latch clears, applied before the sample so a fresh hit wins
    for (int c = 0; c < NCH; c++) begin
      hi_clr = req_i.wr && in_grp(a, `AIAL_HI_CLR_BASE)
               && (grp_idx(a, `AIAL_HI_CLR_BASE) == CW'(c)) && !req_i.wdata[`AIAL_BIT_POS];
      lo_clr = req_i.wr && in_grp(a, `AIAL_LO_CLR_BASE)
               && (grp_idx(a, `AIAL_LO_CLR_BASE) == CW'(c)) && !req_i.wdata[`AIAL_BIT_POS];
      if (hi_clr) begin
        st_nxt.hi_ind[c] = 1'b0;
      end
      if (lo_clr) begin
        st_nxt.lo_ind[c] = 1'b0;
      end
      // disabling the alarm of a channel drops its held indicator
      if (!st_nxt.hi_en[c]) begin
        st_nxt.hi_ind[c] = 1'b0;
      end
      if (!st_nxt.lo_en[c]) begin
        st_nxt.lo_ind[c] = 1'b0;
      end
    end

    // one evaluation per conversion result; out-of-range channels ignored
    if (smp_i.valid && (smp_i.ch < 8'(NCH))) begin
      ix     = smp_i.ch[CW-1:0];
      hi_hit = st_r.hi_en[ix] && (smp_i.value > $signed(st_r.hi_lim[ix]));
      lo_hit = st_r.lo_en[ix] && (smp_i.value < $signed(st_r.lo_lim[ix]));
      if (st_r.hi_type[ix] == `AIAL_MODE_LATCH) begin
        st_nxt.hi_ind[ix] = st_nxt.hi_ind[ix] | hi_hit;
      end else begin
        st_nxt.hi_ind[ix] = hi_hit;
      end
      if (st_r.lo_type[ix] == `AIAL_MODE_LATCH) begin
        st_nxt.lo_ind[ix] = st_nxt.lo_ind[ix] | lo_hit;
      end else begin
        st_nxt.lo_ind[ix] = lo_hit;
      end
      if (!st_r.seen[ix] || (smp_i.value > $signed(st_r.max_v[ix]))) begin
        st_nxt.max_v[ix] = smp_i.value;
      end
      if (!st_r.seen[ix] || (smp_i.value < $signed(st_r.min_v[ix]))) begin
        st_nxt.min_v[ix] = smp_i.value;
      end
      st_nxt.seen[ix] = 1'b1;
    end

    // reads return the state before this cycle's updates
    if (req_i.rd) begin
      st_nxt.rsp.valid = 1'b1;
      if (in_grp(a, `AIAL_HI_EN_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.hi_en[grp_idx(a, `AIAL_HI_EN_BASE)]);
      end else if (in_grp(a, `AIAL_LO_EN_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.lo_en[grp_idx(a, `AIAL_LO_EN_BASE)]);
      end else if (in_grp(a, `AIAL_HI_TYPE_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.hi_type[grp_idx(a, `AIAL_HI_TYPE_BASE)]);
      end else if (in_grp(a, `AIAL_LO_TYPE_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.lo_type[grp_idx(a, `AIAL_LO_TYPE_BASE)]);
      end else if (in_grp(a, `AIAL_HI_CLR_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.hi_ind[grp_idx(a, `AIAL_HI_CLR_BASE)]);
      end else if (in_grp(a, `AIAL_LO_CLR_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.lo_ind[grp_idx(a, `AIAL_LO_CLR_BASE)]);
      end else if (in_grp(a, `AIAL_HI_IND_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.hi_ind[grp_idx(a, `AIAL_HI_IND_BASE)]);
      end else if (in_grp(a, `AIAL_LO_IND_BASE)) begin
        st_nxt.rsp.rdata = bit_word(st_r.lo_ind[grp_idx(a, `AIAL_LO_IND_BASE)]);
      end else if (in_grp(a, `AIAL_MAX_BASE)) begin
        st_nxt.rsp.rdata = st_r.max_v[grp_idx(a, `AIAL_MAX_BASE)];
      end else if (in_grp(a, `AIAL_MIN_BASE)) begin
        st_nxt.rsp.rdata = st_r.min_v[grp_idx(a, `AIAL_MIN_BASE)];
      end else if (in_grp(a, `AIAL_HI_LIM_BASE)) begin
        st_nxt.rsp.rdata = st_r.hi_lim[grp_idx(a, `AIAL_HI_LIM_BASE)];
      end else if (in_grp(a, `AIAL_LO_LIM_BASE)) begin
        st_nxt.rsp.rdata = st_r.lo_lim[grp_idx(a, `AIAL_LO_LIM_BASE)];
      end else begin
        st_nxt.rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r         <= '0;
      st_r.hi_en   <= {NCH{`AIAL_EN_RST}};
      st_r.lo_en   <= {NCH{`AIAL_EN_RST}};
      st_r.hi_type <= {NCH{`AIAL_TYPE_RST}};
      st_r.lo_type <= {NCH{`AIAL_TYPE_RST}};
      st_r.hi_lim  <= {NCH{`AIAL_HI_LIM_RST}};
      st_r.lo_lim  <= {NCH{`AIAL_LO_LIM_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_o      = st_r.rsp;
  assign hi_alarm_o = st_r.hi_ind;
  assign lo_alarm_o = st_r.lo_ind;

endmodule

// ===== aial_alarm_checker.sv
// port assertions for the analog alarm block
`include "aial_map.svh"
module aial_alarm_checker
  import aial_pkg::*;
#(
  parameter int NCH = 32
) (
  input wire logic           core_clk_i,
  input wire logic           srst_i,
  input wire aial_smp_t      smp_i,
  input wire aial_req_t      req_i,
  input wire aial_rsp_t      rsp_o,
  input wire logic [NCH-1:0] hi_alarm_o,
  input wire logic [NCH-1:0] lo_alarm_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  chk_rsp_timing: assert property (1'b1 |=> rsp_o.valid == $past(req_i.rd))
    else $error("read answer not one cycle after request");
  chk_group_end: assert property (req_i.rd && req_i.addr == 16'(`AIAL_HI_TYPE_BASE + NCH)
    |=> rsp_o.err && rsp_o.rdata == 16'h0000) else $error("read past group not refused");
  chk_hi_ind_read: assert property (req_i.rd && req_i.addr == `AIAL_HI_IND_BASE
    |=> rsp_o.rdata == {15'h0000, $past(hi_alarm_o[0])}) else $error("high indicator readback");
  chk_lo_ind_read: assert property (req_i.rd && req_i.addr == `AIAL_LO_IND_BASE
    |=> rsp_o.rdata == {15'h0000, $past(lo_alarm_o[0])}) else $error("low indicator readback");
  chk_hi_hold: assert property (!smp_i.valid && !req_i.wr |=> $stable(hi_alarm_o))
    else $error("high indicator moved without cause");
  chk_lo_hold: assert property (!smp_i.valid && !req_i.wr |=> $stable(lo_alarm_o))
    else $error("low indicator moved without cause");
  chk_hi_cause: assert property ($rose(hi_alarm_o[0]) |-> $past(smp_i.valid && smp_i.ch == 8'h00))
    else $error("high indicator rose without sample");
  chk_lo_cause: assert property ($rose(lo_alarm_o[0]) |-> $past(smp_i.valid && smp_i.ch == 8'h00))
    else $error("low indicator rose without sample");
endmodule

bind aial_alarm aial_alarm_checker #(.NCH(NCH)) aial_alarm_checker_i (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .smp_i(smp_i), .req_i(req_i),
  .rsp_o(rsp_o), .hi_alarm_o(hi_alarm_o), .lo_alarm_o(lo_alarm_o));

// ===== aial_host.sv
// host model issuing register accesses to the alarm block
module aial_host
  import aial_pkg::*;
(
  input  wire logic      core_clk_i,
  output aial_req_t      req_o,
  input  wire aial_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '{1'b0, 1'b0, 16'hFFFF, 16'hFFFF};
  // idle bus shows inverted last values so stale data cannot pass
  task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    repeat ($urandom_range(1)) @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1 req_o = '{w, !w, a, d};
    @(posedge core_clk_i);
    #1 req_o = '{1'b0, 1'b0, ~a, ~d};
    q = rsp_i.rdata;
  endtask
endmodule

// ===== tb.sv
// bench for the analog alarm block: random samples, latch and clear, min/max
`include "aial_map.svh"
module tb;
  import aial_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk_i;
  logic               srst_i;
  aial_smp_t          smp_i;
  aial_req_t          req_i;
  aial_rsp_t          rsp_o;
  logic [1:0]         hi_alarm_o;
  logic [1:0]         lo_alarm_o;
  int                 n_fail;
  int                 comparisons;
  logic signed [15:0] mx;
  logic signed [15:0] mn;
  logic signed [15:0] v;
  logic [15:0]        q;
  aial_alarm #(.NCH(2)) aial_alarm_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .smp_i(smp_i), .req_i(req_i), .rsp_o(rsp_o), .hi_alarm_o(hi_alarm_o), .lo_alarm_o(lo_alarm_o));
  aial_host aial_host_i (.core_clk_i(core_clk_i), .req_o(req_i), .rsp_i(rsp_o));
  task automatic chk_w(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    aial_host_i.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a);
    aial_host_i.acc(1'b0, a, 16'h0000, q);
  endtask
  task automatic samp(input logic [7:0] c, input logic signed [15:0] x);
    @(posedge core_clk_i);
    #1 smp_i = '{1'b1, c, x};
    @(posedge core_clk_i);
    #1 smp_i.valid = 1'b0;
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    srst_i = 1'b1;
    smp_i = '0;
    void'($urandom(32'hCF3785B8));
    repeat (10) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    rd(`AIAL_HI_TYPE_BASE); chk_w(q, 16'h0000);
    chk_b(rsp_o.valid, 1'b1);
    rd(`AIAL_HI_LIM_BASE); chk_w(q, `AIAL_HI_LIM_RST);
    rd(`AIAL_LO_LIM_BASE); chk_w(q, `AIAL_LO_LIM_RST);
    rd(`AIAL_HI_TYPE_BASE + 16'h0002); chk_b(rsp_o.err, 1'b1);
    wr(`AIAL_HI_EN_BASE, 16'h0001);
    wr(`AIAL_LO_EN_BASE, 16'h0001);
    wr(`AIAL_HI_LIM_BASE, 16'h03E8);
    wr(`AIAL_LO_LIM_BASE, 16'hFC18);
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 16'sd1000 : (i == 1) ? -16'sd1000 : 16'($urandom_range(2999)) - 16'sd1500;
      samp(8'h00, v);
      samp(8'h01, v);
      mx = (i == 0 || v > mx) ? v : mx;
      mn = (i == 0 || v < mn) ? v : mn;
      chk_b(hi_alarm_o[0], v > 16'sd1000);
      chk_b(lo_alarm_o[0], v < -16'sd1000);
      chk_b(hi_alarm_o[1] | lo_alarm_o[1], 1'b0);
    end
    rd(`AIAL_MAX_BASE); chk_w(q, mx);
    rd(`AIAL_MIN_BASE); chk_w(q, mn);
    rd(`AIAL_HI_IND_BASE); chk_w(q, {15'h0000, v > 16'sd1000});
    rd(`AIAL_LO_IND_BASE); chk_w(q, {15'h0000, v < -16'sd1000});
    wr(`AIAL_HI_TYPE_BASE, 16'h0001);
    wr(`AIAL_LO_TYPE_BASE, 16'h0001);
    samp(8'h00, 16'sd2000);
    samp(8'h00, -16'sd2000);
    samp(8'h00, 16'sd0);
    chk_b(hi_alarm_o[0], 1'b1);
    chk_b(lo_alarm_o[0], 1'b1);
    wr(`AIAL_HI_CLR_BASE, 16'h0001);
    chk_b(hi_alarm_o[0], 1'b1);
    wr(`AIAL_HI_CLR_BASE, 16'h0000);
    wr(`AIAL_LO_CLR_BASE, 16'h0000);
    chk_b(hi_alarm_o[0], 1'b0);
    chk_b(lo_alarm_o[0], 1'b0);
    complete_run;
  end
endmodule
